// >>> src/icpmb_pkg.sv
package icpmb_pkg;

  // ==========================================================
  // slave address decode
  localparam logic [5:0] main_addr_hi = 6'h10;
  localparam logic [6:0] pp_addr_none = 7'h00;

  // ==========================================================
  // register offsets, field positions and reset values
  localparam logic [7:0] sel_offset = 8'h0e;
  localparam logic [7:0] pp_offset = 8'hfd;
  localparam logic [7:0] sel_reset = 8'h00;
  localparam logic [7:0] pp_reset = 8'h00;
  localparam int sel_lsb = 5;
  localparam int sel_msb = 6;

  // ==========================================================
  // sub map select codes
  localparam logic [1:0] sel_user = 2'h0;
  localparam logic [1:0] sel_intr = 2'h1;
  localparam logic [1:0] sel_user2 = 2'h2;

  // ==========================================================
  // map identifiers, used as upper storage address bits
  localparam logic [1:0] map_user = 2'h0;
  localparam logic [1:0] map_intr = 2'h1;
  localparam logic [1:0] map_user2 = 2'h2;
  localparam logic [1:0] map_vpp = 2'h3;

  // ==========================================================
  // highest subaddress of each map
  localparam logic [7:0] last_user = 8'hff;
  localparam logic [7:0] last_intr = 8'h9f;
  localparam logic [7:0] last_user2 = 8'hef;
  localparam logic [7:0] last_vpp = 8'h7f;

  // ==========================================================
  // storage and serial shape
  localparam int mem_aw = 10;
  localparam int mem_dw = 8;
  localparam logic [2:0] bit_last = 3'h7;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_sub,
    st_write,
    st_read,
    st_ack,
    st_rack
  } icpmb_state_type;

endpackage

// >>> src/icpmb_map_mem.sv
`timescale 1ns/1ns
module icpmb_map_mem
  import icpmb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [icpmb_pkg::mem_aw-1:0] addr,
  input wire logic [icpmb_pkg::mem_dw-1:0] wdata,
  output logic [icpmb_pkg::mem_dw-1:0] rdata
);

  // ==========================================================
  // byte storage for all four maps
  logic [mem_dw-1:0] mem [0:(1<<mem_aw)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  // ==========================================================
  // registered read port
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[addr];
    end
  end

endmodule

// >>> src/icpmb_top.sv
`timescale 1ns/1ns
module icpmb_top
  import icpmb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic serial_clk_pin,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe,
  input wire logic address_select_pin,
  output logic [1:0] sub_map_select,
  output logic [7:0] postproc_map_bus_address
);

  // ==========================================================
  // link domain reset release
  logic lrst_m;
  logic lrst_n;

  always_ff @(posedge link_clk or negedge rstn) begin
    if (!rstn) begin
      lrst_m <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_m <= 1'b1;
      lrst_n <= lrst_m;
    end
  end

  // ==========================================================
  // pin synchronisers and line history
  logic scl_m;
  logic scl_s;
  logic scl_p;
  logic sda_m;
  logic sda_s;
  logic sda_p;
  logic address_select_pin_m;
  logic address_select_pin_s;

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      address_select_pin_m <= 1'b0;
      address_select_pin_s <= 1'b0;
    end else begin
      scl_m <= serial_clk_pin;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= serial_data_pin_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
      address_select_pin_m <= address_select_pin;
      address_select_pin_s <= address_select_pin_m;
    end
  end

  // ==========================================================
  // line events
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

  // ==========================================================
  // link state
  icpmb_state_type st;
  icpmb_state_type next_st;
  icpmb_state_type ack_to;
  icpmb_state_type next_ack_to;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic sda_oe;
  logic next_sda_oe;
  logic [7:0] sub_addr;
  logic [7:0] next_sub_addr;
  logic overrun;
  logic next_overrun;
  logic [1:0] cur_map;
  logic [1:0] next_cur_map;
  logic ph;
  logic next_ph;
  logic [7:0] sel_reg;
  logic [7:0] next_sel_reg;
  logic [7:0] pp_reg;
  logic [7:0] next_pp_reg;
  logic cfg_tgl;
  logic next_cfg_tgl;
  logic byte_we;

  // ==========================================================
  // decode
  logic [7:0] rx_byte;
  logic main_hit;
  logic pp_hit;
  logic [1:0] sel_map;
  logic [7:0] last_sub;
  logic sub_ok;
  logic at_last;
  logic hit_sel;
  logic hit_pp;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;

  assign rx_byte = {shreg[6:0], sda_s};
  assign main_hit = (rx_byte[7:1] == {main_addr_hi, address_select_pin_s});
  assign pp_hit = (pp_reg[7:1] != pp_addr_none) && (rx_byte[7:1] == pp_reg[7:1]);

  always_comb begin
    unique case (sel_reg[sel_msb:sel_lsb])
      sel_intr: sel_map = map_intr;
      sel_user2: sel_map = map_user2;
      default: sel_map = map_user;
    endcase
  end

  always_comb begin
    unique case (cur_map)
      map_intr: last_sub = last_intr;
      map_user2: last_sub = last_user2;
      map_vpp: last_sub = last_vpp;
      default: last_sub = last_user;
    endcase
  end

  assign sub_ok = (rx_byte <= last_sub);
  assign at_last = (sub_addr == last_sub);
  assign hit_sel = (cur_map != map_vpp) && (sub_addr == sel_offset);
  assign hit_pp = (cur_map == map_user) && (sub_addr == pp_offset);
  assign mem_we = byte_we & ~hit_sel & ~hit_pp;
  assign rd_byte = hit_sel ? sel_reg : (hit_pp ? pp_reg : mem_rdata);

  icpmb_map_mem u_mem (
    .clk(link_clk),
    .rst_n(lrst_n),
    .we(mem_we),
    .addr({cur_map, sub_addr}),
    .wdata(rx_byte),
    .rdata(mem_rdata)
  );

  // ==========================================================
  // protocol next state
  always_comb begin
    next_st = st;
    next_ack_to = ack_to;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_sda_oe = sda_oe;
    next_sub_addr = sub_addr;
    next_overrun = overrun;
    next_cur_map = cur_map;
    next_ph = ph;
    next_sel_reg = sel_reg;
    next_pp_reg = pp_reg;
    next_cfg_tgl = cfg_tgl;
    byte_we = 1'b0;
    if (stop_det) begin
      next_st = st_idle;
      next_sda_oe = 1'b0;
    end else if (start_det) begin
      next_st = st_addr;
      next_bit_cnt = 3'h0;
      next_sda_oe = 1'b0;
    end else begin
      unique case (st)
        st_idle: begin
          next_sda_oe = 1'b0;
        end
        st_addr: begin
          if (scl_rise) begin
            next_shreg = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == bit_last) begin
              next_bit_cnt = 3'h0;
              next_ph = 1'b0;
              next_ack_to = rx_byte[0] ? st_read : st_sub;
              if (pp_hit) begin
                next_cur_map = map_vpp;
                next_st = st_ack;
              end else if (main_hit) begin
                next_cur_map = sel_map;
                next_st = st_ack;
              end else begin
                next_st = st_idle;
              end
            end
          end
        end
        st_sub: begin
          if (scl_rise) begin
            next_shreg = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == bit_last) begin
              next_bit_cnt = 3'h0;
              next_ph = 1'b0;
              if (sub_ok) begin
                next_sub_addr = rx_byte;
                next_overrun = 1'b0;
                next_ack_to = st_write;
                next_st = st_ack;
              end else begin
                next_st = st_idle;
              end
            end
          end
        end
        st_write: begin
          if (scl_rise) begin
            next_shreg = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == bit_last) begin
              next_bit_cnt = 3'h0;
              next_ph = 1'b0;
              if (overrun) begin
                next_st = st_idle;
              end else begin
                byte_we = 1'b1;
                next_st = st_ack;
                if (hit_sel) begin
                  next_sel_reg = rx_byte;
                  next_cfg_tgl = ~cfg_tgl;
                end else if (hit_pp) begin
                  next_pp_reg = rx_byte;
                  next_cfg_tgl = ~cfg_tgl;
                end
                if (at_last) begin
                  next_overrun = 1'b1;
                end else begin
                  next_sub_addr = sub_addr + 8'h01;
                end
              end
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            if (!ph) begin
              next_sda_oe = 1'b1;
              next_ph = 1'b1;
            end else begin
              next_ph = 1'b0;
              next_bit_cnt = 3'h0;
              next_st = ack_to;
              if (ack_to == st_read) begin
                next_shreg = rd_byte;
                next_sda_oe = ~rd_byte[7];
              end else begin
                next_sda_oe = 1'b0;
              end
            end
          end
        end
        st_read: begin
          if (scl_fall) begin
            next_sda_oe = ~shreg[6];
            next_shreg = {shreg[6:0], 1'b0};
          end else if (scl_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == bit_last) begin
              next_bit_cnt = 3'h0;
              next_ph = 1'b0;
              next_st = st_rack;
            end
          end
        end
        st_rack: begin
          if (scl_fall && !ph) begin
            next_sda_oe = 1'b0;
            if (at_last) begin
              next_overrun = 1'b1;
            end else begin
              next_sub_addr = sub_addr + 8'h01;
            end
          end else if (scl_rise) begin
            if (sda_s) begin
              next_st = st_idle;
            end else begin
              next_ph = 1'b1;
            end
          end else if (scl_fall && ph) begin
            next_ph = 1'b0;
            next_shreg = rd_byte;
            next_sda_oe = ~rd_byte[7];
            next_st = st_read;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      st <= st_idle;
      ack_to <= st_idle;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      sda_oe <= 1'b0;
      sub_addr <= 8'h00;
      overrun <= 1'b0;
      cur_map <= map_user;
      ph <= 1'b0;
      sel_reg <= sel_reset;
      pp_reg <= pp_reset;
      cfg_tgl <= 1'b0;
    end else begin
      st <= next_st;
      ack_to <= next_ack_to;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      sda_oe <= next_sda_oe;
      sub_addr <= next_sub_addr;
      overrun <= next_overrun;
      cur_map <= next_cur_map;
      ph <= next_ph;
      sel_reg <= next_sel_reg;
      pp_reg <= next_pp_reg;
      cfg_tgl <= next_cfg_tgl;
    end
  end

  assign serial_data_pin_oe = sda_oe;

  // ==========================================================
  // data pin drives only low
  logic sda_out_q;
  logic next_sda_out_q;

  always_comb begin
    next_sda_out_q = 1'b0;
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= next_sda_out_q;
    end
  end

  assign serial_data_pin_out = sda_out_q;

  // ==========================================================
  // configuration crossing to core domain
  logic tgl_m;
  logic tgl_s;
  logic tgl_p;
  logic [1:0] next_sub_map_select;
  logic [7:0] next_postproc_map_bus_address;

  always_comb begin
    next_sub_map_select = sub_map_select;
    next_postproc_map_bus_address = postproc_map_bus_address;
    if (tgl_s != tgl_p) begin
      next_sub_map_select = sel_reg[sel_msb:sel_lsb];
      next_postproc_map_bus_address = pp_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tgl_m <= 1'b0;
      tgl_s <= 1'b0;
      tgl_p <= 1'b0;
      sub_map_select <= sel_user;
      postproc_map_bus_address <= pp_reset;
    end else begin
      tgl_m <= cfg_tgl;
      tgl_s <= tgl_m;
      tgl_p <= tgl_s;
      sub_map_select <= next_sub_map_select;
      postproc_map_bus_address <= next_postproc_map_bus_address;
    end
  end

  // ==========================================================
  // checks
  property p_addr_ack;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_addr && scl_rise && bit_cnt == bit_last && !start_det && !stop_det && main_hit)
      |=> (st == st_ack && !ph) ##0 (!sda_oe);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not taken to acknowledge");

  property p_ack_drive;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_ack && !ph && scl_fall && !start_det && !stop_det) |=> (sda_oe && ph);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven low");

  property p_foreign;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_addr && scl_rise && bit_cnt == bit_last && !start_det && !stop_det && !main_hit && !pp_hit)
      |=> (st == st_idle && !sda_oe);
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address not ignored");

  property p_stop_idle;
    @(posedge link_clk) disable iff (!lrst_n)
    stop_det |=> (st == st_idle && !sda_oe);
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not return to idle");

  property p_start_addr;
    @(posedge link_clk) disable iff (!lrst_n)
    (start_det && !stop_det) |=> (st == st_addr && bit_cnt == 3'h0 && !sda_oe);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start did not restart address phase");

  property p_bad_sub;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_sub && scl_rise && bit_cnt == bit_last && !start_det && !stop_det && !sub_ok)
      |=> (st == st_idle) ##1 (!sda_oe);
  endproperty
  a_bad_sub: assert property (p_bad_sub) else $error("invalid subaddress acknowledged");

  property p_write_over;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_write && scl_rise && bit_cnt == bit_last && !start_det && !stop_det && overrun)
      |-> (!mem_we) ##1 (st == st_idle && $stable(sel_reg) && $stable(pp_reg));
  endproperty
  a_write_over: assert property (p_write_over) else $error("overrun write was accepted");

  property p_step;
    @(posedge link_clk) disable iff (!lrst_n)
    (byte_we && !at_last && !start_det && !stop_det) |=> (sub_addr == $past(sub_addr) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("subaddress did not advance");

  property p_read_hold;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_rack && scl_fall && !ph && at_last && !start_det && !stop_det)
      |=> (sub_addr == $past(sub_addr) && overrun);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read ran past the last subaddress");

  property p_pp_silent;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_addr && scl_rise && bit_cnt == bit_last && !start_det && !stop_det && !main_hit &&
     pp_reg[7:1] == pp_addr_none) |=> (st == st_idle && cur_map == $past(cur_map) && !sda_oe);
  endproperty
  a_pp_silent: assert property (p_pp_silent) else $error("unprogrammed postprocessor map answered");

  property p_route;
    @(posedge link_clk) disable iff (!lrst_n)
    (st == st_addr && scl_rise && bit_cnt == bit_last && !start_det && !stop_det && main_hit && !pp_hit)
      |=> (cur_map == (($past(sel_reg[sel_msb:sel_lsb]) == sel_intr) ? map_intr :
                       (($past(sel_reg[sel_msb:sel_lsb]) == sel_user2) ? map_user2 : map_user)));
  endproperty
  a_route: assert property (p_route) else $error("sub map routed wrongly");

endmodule

// >>> tb/icpmb_master.sv
`timescale 1ns/1ns
// ==========================================================
// two-wire bus master, open drain, line released reads high
module icpmb_master (
  input wire logic core_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic w();
    repeat (25) @(negedge core_clk);
  endtask

  task automatic start();
    sda_drv = 1'b1;
    w();
    scl = 1'b1;
    w();
    sda_drv = 1'b0;
    w();
    scl = 1'b0;
  endtask

  task automatic stop();
    w();
    sda_drv = 1'b0;
    w();
    scl = 1'b1;
    w();
    sda_drv = 1'b1;
    w();
  endtask

  task automatic put_bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      w();
      sda_drv = b[7-i];
      w();
      scl = 1'b1;
      w();
      scl = 1'b0;
    end
  endtask

  task automatic get_bit(output logic v);
    w();
    sda_drv = 1'b1;
    w();
    scl = 1'b1;
    w();
    v = sda_wire;
    scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic v;
    put_bits(b, 8);
    get_bit(v);
    ack = ~v;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] q);
    logic v;
    for (int i = 0; i < 8; i++) begin
      get_bit(v);
      q[7-i] = v;
    end
    put_bits({last, 7'h00}, 1);
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`define chk(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import icpmb_pkg::*;
  logic core_clk = 1'b0;
  logic link_clk = 1'b1;
  logic rstn = 1'b0;
  logic address_select_pin = 1'b0;
  logic scl, sda_drv, sda_wire, sdo, oe;
  logic [1:0] sub_map_select;
  logic [7:0] pp;
  int fail_count = 0;
  int tests_run = 0;

  always #2 core_clk = ~core_clk;
  always #3 link_clk = ~link_clk;
  // pull-up wins unless someone pulls low
  assign sda_wire = ~((oe & ~sdo) | ~sda_drv);

  icpmb_top i_icpmb_top (
    .core_clk(core_clk),
    .rstn(rstn),
    .link_clk(link_clk),
    .serial_clk_pin(scl),
    .serial_data_pin_in(sda_wire),
    .serial_data_pin_out(sdo),
    .serial_data_pin_oe(oe),
    .address_select_pin(address_select_pin),
    .sub_map_select(sub_map_select),
    .postproc_map_bus_address(pp)
  );

  icpmb_master i_icpmb_master (
    .core_clk(core_clk),
    .sda_wire(sda_wire),
    .scl(scl),
    .sda_drv(sda_drv)
  );

  // ==========================================================
  // transfers
  task automatic wr(input logic [47:0] b, input int n, input logic [5:0] exp, input string nm);
    logic [5:0] ack;
    logic a;
    ack = '0;
    i_icpmb_master.start();
    for (int i = 0; i < n; i++) begin
      i_icpmb_master.put_byte(b[47-8*i -: 8], a);
      ack[i] = a;
    end
    i_icpmb_master.stop();
    `chk(nm, exp, ack)
  endtask

  task automatic rd(input logic [7:0] a, input int n, input logic [23:0] exp, input string nm);
    logic [23:0] q;
    logic ack;
    q = '0;
    i_icpmb_master.start();
    i_icpmb_master.put_byte(a, ack);
    `chk("read ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      i_icpmb_master.get_byte(i == n - 1, q[23-8*i -: 8]);
    end
    i_icpmb_master.stop();
    `chk(nm, exp, q)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    `chk("sel", sel_user, sub_map_select)
    `chk("pp", pp_reset, pp)
    `chk("oe", 1'b0, oe)
    `chk("sdo", 1'b0, sdo)
    $display("done reset");
  endtask

  task automatic t_addr();
    for (int p = 0; p < 2; p++) begin
      address_select_pin = p[0];
      for (int k = 0; k < 2; k++) begin
        wr({8'h40 | 8'(2 * k), 40'h0}, 1, {5'h0, k == p}, "main addr");
      end
      wr(48'h840000000000, 1, 6'h00, "pp silent");
    end
    address_select_pin = 1'b0;
    $display("done addr");
  endtask

  task automatic t_pp();
    wr(48'h40fd84000000, 3, 6'h07, "pp prog");
    `chk("pp", 8'h84, pp)
    for (int p = 0; p < 2; p++) begin
      address_select_pin = p[0];
      wr({8'h84, 8'h10, 8'ha0 | 8'(p), 24'h0}, 3, 6'h07, "pp wr addr");
      wr(48'h841000000000, 2, 6'h03, "pp set sub");
      rd(8'h85, 1, {8'ha0 | 8'(p), 16'h0}, "pp rd addr");
    end
    address_select_pin = 1'b0;
    $display("done pp");
  endtask

  task automatic t_incr();
    wr(48'h40fd865aa533, 6, 6'h1f, "overrun wr");
    `chk("pp", 8'h86, pp)
    wr(48'h40fe00000000, 2, 6'h03, "set sub");
    rd(8'h41, 3, 24'h5aa5a5, "overrun rd");
    $display("done incr");
  endtask

  task automatic t_sel();
    logic [7:0] e;
    logic u;
    e = 8'h86;
    for (int c = 0; c < 4; c++) begin
      wr({8'h40, 8'h0e, 1'b0, c[1:0], 5'h0, 24'h0}, 3, 6'h07, "sel wr");
      `chk("sel", c[1:0], sub_map_select)
      u = (c == 0) || (c == 3);
      wr({8'h40, 8'hfd, 8'h90 + 8'(2 * c), 24'h0}, 3, u ? 6'h07 : 6'h01, "sub range");
      if (u) begin
        e = 8'h90 + 8'(2 * c);
      end
      `chk("pp", e, pp)
      wr({e, 40'h0}, 1, 6'h01, "pp probe");
    end
    wr(48'h400e00000000, 3, 6'h07, "sel back");
    `chk("sel", sel_user, sub_map_select)
    $display("done sel");
  endtask

  task automatic t_abort();
    logic a;
    i_icpmb_master.start();
    i_icpmb_master.put_bits(8'h40, 3);
    i_icpmb_master.start();
    i_icpmb_master.put_byte(8'h40, a);
    `chk("restart ack", 1'b1, a)
    i_icpmb_master.put_byte(8'h0e, a);
    `chk("sub ack", 1'b1, a)
    i_icpmb_master.put_bits(8'h20, 4);
    i_icpmb_master.stop();
    `chk("partial", sel_user, sub_map_select)
    wr(48'h400e20000000, 3, 6'h07, "after abort");
    `chk("sel", sel_intr, sub_map_select)
    $display("done abort");
  endtask

  task automatic end_of_test();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (10) @(negedge core_clk);
    t_reset();
    t_addr();
    t_pp();
    t_incr();
    t_sel();
    t_abort();
    end_of_test();
  end
endmodule
